// ==== fcsis_top.sv ====
// Status, fault interrupt, build parameter, statistics and identification registers
// ==========================================================
// What this block does
// [R1] Status bit 4 mirrors registered power acknowledge
// [R2] Status bit 2 shows invalidation in progress
// [R3] Status [1:0] reports the four cache states
// [R4] Mask bit zero passes event, one suppresses
// [R5] Mask bit 1 invalidation, bit 0 power
// [R6] Fault flags set regardless of mask
// [R7] Invalidation request outside disabled sets flag
// [R8] Power acknowledge or manual request drop faults
// [R9] Writing one clears a flag, zero keeps
// [R10] Build word bit 13 shows STATS_BUILT, bit 12 reads one
// [R11] Build word bits [11:10] give two ways
// [R12] Build word bits [9:5] way size code
// [R13] Build word bits [4:0] flash address width
// [R14] Hit counter counts hits when stats enabled
// [R15] Miss counter counts misses when stats enabled
// [R16] Only cacheable reads touch the counters
// [R17] Any counter write clears it; a same-cycle lookup still counts
// [R18] Absent counters still answer OKAY
// [R19] Ident word 4 read-only, continuation code
// [R20] Ident word 0 part low, others zero
// [R21] Software requests invalidation only while disabled
// [R22] Manual power request checked in manual mode
// [R23] Interrupt is OR of unmasked flags, level
module fcsis_top #(
    parameter logic STATS_BUILT = 1'b1,
    // Arbitrary neutral identity values
    parameter logic [3:0] IDENT_CONT_CODE = 4'h7,
    parameter logic [7:0] IDENT_PART_LOW = 8'h5a
) (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    input wire logic [2:0] PPROT_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire fcsis_pkg::fcsis_ctrl_t CTRL_I,
    input wire fcsis_pkg::fcsis_lookup_t LOOKUP_I,
    input wire logic SRAM_POWER_ACK_IN_I,
    output logic [1:0] CACHE_STATE_O,
    output logic MANUAL_INVALIDATE_FAULT_O,
    output logic POWER_FAULT_O,
    output logic IRQ_O
);
    import fcsis_pkg::*;

    // ==========================================================
    // Reset release
    logic rst_meta_q;
    logic rst_n_q;

    // Synchronised release lets every flop on rst_n_q leave reset on one edge
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // Address decode, shared by read and write paths
    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction : is_reg

    // ==========================================================
    // Bus access: one wait state, so data and ready come from flops
    logic pready_q;
    logic [31:0] prdata_q;
    logic access;
    logic wr_done;

    // Ready masks access so the ready cycle never starts a second transfer
    assign access = PSEL_I && PENABLE_I && !pready_q;
    assign wr_done = PSEL_I && PENABLE_I && pready_q && PWRITE_I;

    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access;
        end
    end

    // ==========================================================
    // Cache state machine
    fcsis_state_t state_q;
    fcsis_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_DISABLED: begin
                if (CTRL_I.cache_enable) begin
                    state_d = ST_ENABLING;
                end
            end
            // Dropping enable mid-way aborts straight to disabling
            ST_ENABLING: begin
                if (!CTRL_I.cache_enable) begin
                    state_d = ST_DISABLING;
                end else if (CTRL_I.enable_done) begin
                    state_d = ST_ENABLED;
                end
            end
            ST_ENABLED: begin
                if (!CTRL_I.cache_enable) begin
                    state_d = ST_DISABLING;
                end
            end
            ST_DISABLING: begin
                if (CTRL_I.disable_done) begin
                    state_d = ST_DISABLED;
                end
            end
            default: begin
                state_d = ST_DISABLED;
            end
        endcase
    end

    // [R3] State tracking
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_DISABLED;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Status inputs
    logic power_ack_view_q;
    logic invalidation_active_q;
    logic inval_req_q;
    logic power_req_q;

    // [R1] Registered acknowledge
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            power_ack_view_q <= 1'b0;
        end else begin
            power_ack_view_q <= SRAM_POWER_ACK_IN_I;
        end
    end

    // [R2] Invalidation busy view
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            invalidation_active_q <= 1'b0;
        end else begin
            invalidation_active_q <= CTRL_I.inval_busy;
        end
    end

    // Previous request levels, for edge detection
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            inval_req_q <= 1'b0;
            power_req_q <= 1'b0;
        end else begin
            inval_req_q <= CTRL_I.manual_invalidate_request;
            power_req_q <= CTRL_I.manual_power_request;
        end
    end

    // ==========================================================
    // Fault events
    logic inval_event;
    logic power_event;
    logic ack_drop;
    logic req_drop;

    // [R7] Request raised while not disabled; software should avoid this [R21]
    assign inval_event = CTRL_I.manual_invalidate_mode && CTRL_I.manual_invalidate_request
        && !inval_req_q && (state_q != ST_DISABLED);
    // [R8] Acknowledge lost while the cache is in use
    assign ack_drop = power_ack_view_q && !SRAM_POWER_ACK_IN_I && (state_q != ST_DISABLED);
    // [R22] Manual request dropped only counts in manual power mode
    assign req_drop = CTRL_I.manual_power_mode && power_req_q
        && !CTRL_I.manual_power_request && (state_q == ST_ENABLED);
    assign power_event = ack_drop || req_drop;

    // ==========================================================
    // Mask and fault flags
    logic [FAULT_W-1:0] mask_q;
    logic [FAULT_W-1:0] flags_q;
    logic [FAULT_W-1:0] flags_set;
    logic [FAULT_W-1:0] flags_clr;

    assign flags_set = {inval_event, power_event};
    // Both flag bits sit in byte lane 0
    assign flags_clr = (wr_done && is_reg(PADDR_I, OFS_IRQ_FLAGS) && PSTRB_I[0])
        ? PWDATA_I[FAULT_W-1:0] : '0;

    // [R4] Mask register, cleared at reset
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= MASK_RESET;
        end else if (wr_done && is_reg(PADDR_I, OFS_IRQ_MASK) && PSTRB_I[0]) begin
            mask_q <= PWDATA_I[FAULT_W-1:0];
        end
    end

    // [R6] Set regardless of mask; an event beats a same-cycle clear
    // [R9] Write-one-to-clear
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flags_q <= FLAGS_RESET;
        end else begin
            flags_q <= (flags_q & ~flags_clr) | flags_set;
        end
    end

    // [R5] Bit 1 gates invalidation fault, bit 0 power fault
    // [R23] Level request from unmasked flags
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(flags_q & ~mask_q);
        end
    end

    // ==========================================================
    // Statistics counters
    logic [31:0] hit_cnt_q;
    logic [31:0] miss_cnt_q;
    logic lookup_ok;
    logic hit_inc;
    logic miss_inc;

    // [R16] Only cacheable reads are looked up
    assign lookup_ok = LOOKUP_I.valid && LOOKUP_I.read && LOOKUP_I.cacheable
        && CTRL_I.stats_enable && STATS_BUILT;
    assign hit_inc = lookup_ok && LOOKUP_I.hit;
    assign miss_inc = lookup_ok && !LOOKUP_I.hit;

    // Counters wrap at all ones; software clears them before long runs
    // [R14] Hit counting
    // [R17] Any write clears; a lookup in that cycle still counts
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hit_cnt_q <= CNT_RESET;
        end else if (wr_done && is_reg(PADDR_I, OFS_HIT_CNT)) begin
            hit_cnt_q <= {31'h0000_0000, hit_inc};
        end else if (hit_inc) begin
            hit_cnt_q <= hit_cnt_q + 32'h0000_0001;
        end
    end

    // [R15] Miss counting
    // [R17] Clear on write
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            miss_cnt_q <= CNT_RESET;
        end else if (wr_done && is_reg(PADDR_I, OFS_MISS_CNT)) begin
            miss_cnt_q <= {31'h0000_0000, miss_inc};
        end else if (miss_inc) begin
            miss_cnt_q <= miss_cnt_q + 32'h0000_0001;
        end
    end

    // ==========================================================
    // Read mux
    logic [31:0] rd_d;

    // Build word kept in one place so the read mux stays flat
    function automatic logic [31:0] build_word(input logic stats);
        logic [31:0] w;
        w = 32'h0000_0000;
        // [R10] Build options
        w[BUILD_STATS_BIT] = stats;
        w[BUILD_RSTALL_BIT] = RESET_ALL_REGS;
        // [R11] Way count
        w[BUILD_WAYS_LSB +: 2] = WAYS_CODE;
        // [R12] Way size
        w[BUILD_WAYSZ_LSB +: 5] = WAY_SIZE_CODE;
        // [R13] Flash address width
        w[BUILD_ADDR_WIDTH_LSB +: 5] = FLASH_ADDR_WIDTH_CODE;
        return w;
    endfunction : build_word

    always_comb begin
        // [R20] Holes and unused ident words read zero
        rd_d = 32'h0000_0000;
        if (is_reg(PADDR_I, OFS_STATUS)) begin
            rd_d[STAT_POWER_ACK_BIT] = power_ack_view_q;
            rd_d[STAT_INVAL_BIT] = invalidation_active_q;
            rd_d[STAT_STATE_LSB +: 2] = state_q;
        end else if (is_reg(PADDR_I, OFS_IRQ_MASK)) begin
            rd_d[FAULT_W-1:0] = mask_q;
        end else if (is_reg(PADDR_I, OFS_IRQ_FLAGS)) begin
            rd_d[FAULT_W-1:0] = flags_q;
        end else if (is_reg(PADDR_I, OFS_BUILD)) begin
            rd_d = build_word(STATS_BUILT);
        end else if (is_reg(PADDR_I, OFS_HIT_CNT)) begin
            // [R18] Absent counters read zero, still OKAY
            rd_d = STATS_BUILT ? hit_cnt_q : 32'h0000_0000;
        end else if (is_reg(PADDR_I, OFS_MISS_CNT)) begin
            rd_d = STATS_BUILT ? miss_cnt_q : 32'h0000_0000;
        end else if (is_reg(PADDR_I, OFS_IDENT_4)) begin
            // [R19] Continuation code, size zero
            rd_d[3:0] = IDENT_CONT_CODE;
            rd_d[IDENT_SIZE_LSB +: 4] = IDENT_SIZE;
        end else if (is_reg(PADDR_I, OFS_IDENT_0)) begin
            // [R20] Low part number byte
            rd_d[7:0] = IDENT_PART_LOW;
        end
    end

    // Data only loads on reads, so writes never disturb it
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prdata_q <= 32'h0000_0000;
        end else if (access && !PWRITE_I) begin
            prdata_q <= rd_d;
        end
    end

    // ==========================================================
    // Outputs
    // [R3] State pins follow the state register
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            CACHE_STATE_O <= 2'h0;
        end else begin
            CACHE_STATE_O <= state_d;
        end
    end

    // [R7] Invalidation fault pulse, same edge as its flag
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            MANUAL_INVALIDATE_FAULT_O <= 1'b0;
        end else begin
            MANUAL_INVALIDATE_FAULT_O <= inval_event;
        end
    end

    // [R8] Power fault pulse, same edge as its flag
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            POWER_FAULT_O <= 1'b0;
        end else begin
            POWER_FAULT_O <= power_event;
        end
    end

    // [R18] Never an error response, absent counters included
    always_ff @(posedge MCLK_I or negedge rst_n_q) begin
        if (!rst_n_q) begin
            PSLVERR_O <= 1'b0;
        end else begin
            PSLVERR_O <= 1'b0;
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;

endmodule : fcsis_top

// ==== fcsis_pkg.sv ====
// Package: register map, field layout and types of the flash cache status block
package fcsis_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
    localparam logic [11:0] OFS_IRQ_FLAGS = 12'h00c;
    localparam logic [11:0] OFS_BUILD = 12'h010;
    localparam logic [11:0] OFS_HIT_CNT = 12'h014;
    localparam logic [11:0] OFS_MISS_CNT = 12'h018;
    localparam logic [11:0] OFS_IDENT_4 = 12'hfd0;
    localparam logic [11:0] OFS_IDENT_5 = 12'hfd4;
    localparam logic [11:0] OFS_IDENT_6 = 12'hfd8;
    localparam logic [11:0] OFS_IDENT_7 = 12'hfdc;
    localparam logic [11:0] OFS_IDENT_0 = 12'hfe0;

    // ==========================================================
    // Field positions
    localparam int STAT_POWER_ACK_BIT = 4;
    localparam int STAT_INVAL_BIT = 2;
    localparam int STAT_STATE_LSB = 0;
    localparam int FAULT_INVAL_BIT = 1;
    localparam int FAULT_POWER_BIT = 0;
    localparam int FAULT_W = 2;
    localparam int BUILD_STATS_BIT = 13;
    localparam int BUILD_RSTALL_BIT = 12;
    localparam int BUILD_WAYS_LSB = 10;
    localparam int BUILD_WAYSZ_LSB = 5;
    localparam int BUILD_ADDR_WIDTH_LSB = 0;
    localparam int IDENT_SIZE_LSB = 4;

    // ==========================================================
    // Reset and build values
    localparam logic [FAULT_W-1:0] MASK_RESET = 2'h0;
    localparam logic [FAULT_W-1:0] FLAGS_RESET = 2'h0;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic RESET_ALL_REGS = 1'b1;
    localparam logic [1:0] WAYS_CODE = 2'h2;
    localparam logic [4:0] WAY_SIZE_CODE = 5'h0c;
    localparam logic [4:0] FLASH_ADDR_WIDTH_CODE = 5'h12;
    localparam logic [3:0] IDENT_SIZE = 4'h0;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_DISABLED,
        ST_ENABLING,
        ST_ENABLED,
        ST_DISABLING
    } fcsis_state_t;

    typedef struct packed {
        logic valid;
        logic read;
        logic cacheable;
        logic hit;
    } fcsis_lookup_t;

    typedef struct packed {
        logic cache_enable;
        logic enable_done;
        logic disable_done;
        logic inval_busy;
        logic manual_invalidate_mode;
        logic manual_invalidate_request;
        logic manual_power_mode;
        logic manual_power_request;
        logic stats_enable;
    } fcsis_ctrl_t;

endpackage : fcsis_pkg

// ==== fcsis_top_properties.sv ====
// Checker: timing relations on the ports of the status block
module fcsis_top_chk (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire fcsis_pkg::fcsis_ctrl_t CTRL_I,
    input wire logic SRAM_POWER_ACK_IN_I,
    input wire logic [1:0] CACHE_STATE_O,
    input wire logic MANUAL_INVALIDATE_FAULT_O,
    input wire logic POWER_FAULT_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    import fcsis_pkg::*;
    logic [1:0] up_q;
    logic live;
    logic wr_done;
    // ========
    // Helpers
    // Internal reset copy lags two edges, so hold off the ready, state and fault checks
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    assign live = (up_q == 2'h3);
    assign wr_done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RSTN_I);
    // ========
    // Properties
    chk_ready_one_wait: assert property (live && PSEL_I && PENABLE_I && !PREADY_O
        |=> PREADY_O ##1 !PREADY_O) else $error("ready not one cycle");
    chk_okay_resp: assert property (PREADY_O |-> !PSLVERR_O && PSEL_I && PENABLE_I)
        else $error("bad response");
    chk_rdata_hold: assert property ($changed(PRDATA_O) |-> PREADY_O)
        else $error("read data moved");
    chk_irq_rise_cause: assert property ($rose(IRQ_O) |-> $past(MANUAL_INVALIDATE_FAULT_O)
        || $past(POWER_FAULT_O) || $past(wr_done, 2)) else $error("irq rose without cause");
    chk_irq_fall_cause: assert property ($fell(IRQ_O) |-> $past(wr_done, 2))
        else $error("irq fell without write");
    chk_state_enable: assert property (live && CACHE_STATE_O == 2'h0 && CTRL_I.cache_enable
        |=> CACHE_STATE_O == 2'h1) else $error("no enabling state");
    chk_state_done: assert property (live && CACHE_STATE_O == 2'h1 && CTRL_I.cache_enable
        && CTRL_I.enable_done |=> CACHE_STATE_O == 2'h2) else $error("no enabled state");
    chk_state_off: assert property (live && CACHE_STATE_O == 2'h3 && CTRL_I.disable_done
        |=> CACHE_STATE_O == 2'h0) else $error("no disabled state");
    chk_inval_fault: assert property (live && $rose(CTRL_I.manual_invalidate_request)
        && CTRL_I.manual_invalidate_mode && CACHE_STATE_O != 2'h0
        |=> MANUAL_INVALIDATE_FAULT_O) else $error("missed invalidation fault");
    chk_power_fault: assert property (live && (($fell(SRAM_POWER_ACK_IN_I)
        && CACHE_STATE_O != 2'h0) || ($fell(CTRL_I.manual_power_request)
        && CTRL_I.manual_power_mode && CACHE_STATE_O == 2'h2))
        |=> POWER_FAULT_O) else $error("missed power fault");
    cov_irq: cover property ($rose(IRQ_O));
    cov_inval: cover property (MANUAL_INVALIDATE_FAULT_O);
    cov_power: cover property (POWER_FAULT_O);
endmodule : fcsis_top_chk

bind fcsis_top fcsis_top_chk u_chk (.MCLK_I, .RSTN_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
    .PRDATA_O, .PREADY_O, .PSLVERR_O, .CTRL_I, .SRAM_POWER_ACK_IN_I, .CACHE_STATE_O,
    .MANUAL_INVALIDATE_FAULT_O, .POWER_FAULT_O, .IRQ_O);

// ==== fcsis_apb_master.sv ====
// Partner model: register-port master issuing single transfers
module fcsis_apb_master (
    input wire logic clk_i,
    input wire logic pready_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h0;
        pwdata_o = 32'h0;
    end
    // Request held until the edge that samples ready high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        @(negedge clk_i);
        psel_o = 1'b1;
        pwrite_o = w;
        paddr_o = a;
        pwdata_o = d;
        @(negedge clk_i);
        penable_o = 1'b1;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 8);
        ok = (pready_i === 1'b1);
        q = prdata_i;
        @(negedge clk_i);
        psel_o = 1'b0;
        penable_o = 1'b0;
        // Released lines must not keep the old value
        paddr_o = ~a;
        pwdata_o = ~d;
    endtask : xfer
endmodule : fcsis_apb_master

// ==== tb_fcsis_top.sv ====
// Testbench: register, fault, interrupt and statistics scenarios
module tb_fcsis_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fcsis_pkg::*;
    logic mclk, rstn, psel, penable, pwrite, pready, pslverr, ack, irq, finv, fpow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] cstate;
    fcsis_ctrl_t ctl;
    fcsis_lookup_t lk;
    int errors, checks, cyc;
    // Arbitrary identity values
    fcsis_top #(.STATS_BUILT(1'b1), .IDENT_CONT_CODE(4'h3), .IDENT_PART_LOW(8'hc6)) uut (
        .MCLK_I(mclk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PPROT_I(3'h0), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .CTRL_I(ctl), .LOOKUP_I(lk),
        .SRAM_POWER_ACK_IN_I(ack), .CACHE_STATE_O(cstate), .MANUAL_INVALIDATE_FAULT_O(finv),
        .POWER_FAULT_O(fpow), .IRQ_O(irq));
    fcsis_apb_master mst (.clk_i(mclk), .pready_i(pready), .prdata_i(prdata), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
    // ========
    // Shared tasks
    task automatic end_sim;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        logic ok;
        mst.xfer(1'b0, a, 32'h0, q, ok);
        chk(n, q, e);
        chk("read ready", {30'h0, pslverr, ok}, 32'h1);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic ok;
        mst.xfer(1'b1, a, d, q, ok);
        chk("write ready", {30'h0, pslverr, ok}, 32'h1);
    endtask : wr
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_n
    task automatic go(input logic on);
        ctl.cache_enable = on;
        wait_n(1);
        ctl.enable_done = on;
        ctl.disable_done = !on;
        wait_n(1);
        ctl.enable_done = 1'b0;
        ctl.disable_done = 1'b0;
        wait_n(2);
    endtask : go
    task automatic pulse(input logic r, input logic c, input logic h, input int n);
        repeat (n) begin
            @(negedge mclk);
            lk = '{valid: 1'b1, read: r, cacheable: c, hit: h};
            @(negedge mclk);
            lk = '0;
        end
    endtask : pulse
    // ========
    // Scenarios
    task automatic t_params;
        rd(OFS_STATUS, 32'h0, "status reset");
        rd(OFS_IRQ_MASK, 32'h0, "mask reset");
        rd(OFS_BUILD, 32'h0000_3992, "build");
        wr(OFS_IDENT_4, 32'hffff_ffff);
        rd(OFS_IDENT_4, 32'h0000_0003, "ident4");
        rd(OFS_IDENT_0, 32'h0000_00c6, "ident0");
        rd(OFS_IDENT_5, 32'h0, "ident5");
        rd(OFS_IDENT_6, 32'h0, "ident6");
        rd(OFS_IDENT_7, 32'h0, "ident7");
        rd(12'h01c, 32'h0, "unmapped");
    endtask : t_params
    task automatic t_status;
        ack = 1'b1;
        ctl.inval_busy = 1'b1;
        ctl.cache_enable = 1'b1;
        rd(OFS_STATUS, 32'h15, "status enabling");
        ctl.enable_done = 1'b1;
        wait_n(1);
        ctl.enable_done = 1'b0;
        rd(OFS_STATUS, 32'h16, "status enabled");
        ctl.inval_busy = 1'b0;
        ctl.cache_enable = 1'b0;
        wait_n(2);
        chk("state pin", {30'h0, cstate}, 32'h3);
        rd(OFS_STATUS, 32'h13, "status disabling");
        go(1'b0);
        rd(OFS_STATUS, 32'h10, "status idle");
    endtask : t_status
    task automatic t_faults;
        ctl.manual_invalidate_mode = 1'b1;
        ctl.manual_invalidate_request = 1'b1;
        wait_n(2);
        ctl.manual_invalidate_request = 1'b0;
        rd(OFS_IRQ_FLAGS, 32'h0, "flags while off");
        wr(OFS_IRQ_MASK, 32'h2);
        go(1'b1);
        // Request while enabled, broken on purpose
        ctl.manual_invalidate_request = 1'b1;
        wait_n(1);
        chk("inval pulse", {31'h0, finv}, 32'h1);
        wait_n(2);
        chk("irq masked", {31'h0, irq}, 32'h0);
        ack = 1'b0;
        wait_n(1);
        chk("power pulse", {31'h0, fpow}, 32'h1);
        wait_n(2);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        chk("pulses end", {30'h0, finv, fpow}, 32'h0);
        rd(OFS_IRQ_FLAGS, 32'h3, "both flags");
        wr(OFS_IRQ_FLAGS, 32'h0);
        rd(OFS_IRQ_FLAGS, 32'h3, "zero write keeps");
        wr(OFS_IRQ_FLAGS, 32'h1);
        wait_n(1);
        chk("irq after clear", {31'h0, irq}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h0);
        wait_n(1);
        chk("irq after unmask", {31'h0, irq}, 32'h1);
        wr(OFS_IRQ_FLAGS, 32'h2);
        rd(OFS_IRQ_FLAGS, 32'h0, "flags cleared");
        ack = 1'b1;
        ctl.manual_invalidate_request = 1'b0;
        ctl.manual_power_mode = 1'b1;
        ctl.manual_power_request = 1'b1;
        wait_n(2);
        ctl.manual_power_request = 1'b0;
        rd(OFS_IRQ_FLAGS, 32'h1, "manual power drop");
        wr(OFS_IRQ_FLAGS, 32'h1);
        ctl.cache_enable = 1'b0;
        wait_n(1);
        go(1'b0);
    endtask : t_faults
    task automatic t_stats;
        ctl.stats_enable = 1'b1;
        pulse(1'b1, 1'b1, 1'b1, 2);
        wr(OFS_HIT_CNT, 32'h0);
        pulse(1'b1, 1'b1, 1'b1, 3);
        pulse(1'b1, 1'b1, 1'b0, 2);
        // Uncacheable read and cacheable write are not counted
        pulse(1'b1, 1'b0, 1'b1, 1);
        pulse(1'b0, 1'b1, 1'b0, 1);
        ctl.stats_enable = 1'b0;
        pulse(1'b1, 1'b1, 1'b1, 1);
        rd(OFS_HIT_CNT, 32'h3, "hits");
        rd(OFS_MISS_CNT, 32'h2, "misses");
        wr(OFS_MISS_CNT, 32'h5a5a_0001);
        rd(OFS_MISS_CNT, 32'h0, "miss cleared");
    endtask : t_stats
    // ========
    // Clock, reset, watchdog and sequence
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        rstn = 1'b0;
        ack = 1'b0;
        ctl = '0;
        lk = '0;
        wait_n(5);
        rstn = 1'b1;
        wait_n(3);
        t_params();
        t_status();
        t_faults();
        t_stats();
        end_sim();
    end
endmodule : tb_fcsis_top
